// *** gp_params.svh ***
// What this block does
// - Each port bit is set to input or output by its direction register bit.
// - Port 0 has four bits, port 2 six, ports 4 and 5 two each.
// - Each pull-up register bit switches the pull-up of its own pin.
// - Reset clears every direction bit and every pull-up enable bit.
// - While external reset is low, all port control state stays initialised.
// - After reset rises, a timed stabilisation wait passes before the block runs.
// - Port 2 serial function reaches a pin only when selected; direction still rules.
`ifndef GP_PARAMS_SVH
`define GP_PARAMS_SVH

`define GP_P0_WIDTH        4
`define GP_P2_WIDTH        6
`define GP_P4_WIDTH        2
`define GP_P5_WIDTH        2
`define GP_MAX_WIDTH       31

`define GP_ADDR_W          8
`define GP_OFS_P0_DATA     8'h00
`define GP_OFS_P0_DIR      8'h04
`define GP_OFS_P0_PULL     8'h08
`define GP_OFS_P0_PIN      8'h0c
`define GP_OFS_P2_DATA     8'h10
`define GP_OFS_P2_DIR      8'h14
`define GP_OFS_P2_PULL     8'h18
`define GP_OFS_P2_PIN      8'h1c
`define GP_OFS_P4_DATA     8'h20
`define GP_OFS_P4_DIR      8'h24
`define GP_OFS_P4_PULL     8'h28
`define GP_OFS_P4_PIN      8'h2c
`define GP_OFS_P5_DATA     8'h30
`define GP_OFS_P5_DIR      8'h34
`define GP_OFS_P5_PULL     8'h38
`define GP_OFS_P5_PIN      8'h3c
`define GP_OFS_P2_FUNC     8'h40

`define GP_DIR_RST         1'b0
`define GP_PULL_RST        1'b0
`define GP_DATA_RST        1'b0
`define GP_FUNC_RST        1'b0
`define GP_RDATA_RST       32'h0000_0000
`define GP_HRESP_OKAY      1'b0
`define GP_HTRANS_ACT_BIT  1

`define GP_CLK_PERIOD_NS   10
`define GP_STAB_TIME_NS    10000
`define GP_STAB_CYCLES     ((`GP_STAB_TIME_NS + `GP_CLK_PERIOD_NS - 1) / `GP_CLK_PERIOD_NS)

`endif

// *** gp_pkg.sv ***
`default_nettype none
package gp_pkg;

    typedef enum logic [2:0] {
        GP_BUS_IDLE  = 3'b001,
        GP_BUS_WRITE = 3'b010,
        GP_BUS_READ  = 3'b100
    } gp_bus_state_e;

endpackage : gp_pkg
`default_nettype wire

// *** gp_reset_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module gp_reset_ctl #(
    parameter int STAB_CYCLES = `GP_STAB_CYCLES
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      run
);
    import gp_pkg::*;

    localparam int CW = $clog2(STAB_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STAB_CYCLES);

    logic [CW-1:0] count;

    generate
        if (STAB_CYCLES < 1) begin : g_bad
            $error("gp_reset_ctl: STAB_CYCLES must be at least one");
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (count != LAST) begin
            count <= count + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run <= 1'b0;
        end else begin
            run <= (count == LAST);
        end
    end

endmodule : gp_reset_ctl
`default_nettype wire

// *** gp_port_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module gp_port_bank #(
    parameter int W = `GP_P0_WIDTH
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         run,
    input  wire logic         wr_data,
    input  wire logic         wr_dir,
    input  wire logic         wr_pull,
    input  wire logic [W-1:0] wdata,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] func_sel,
    input  wire logic [W-1:0] alt_out,
    output logic      [W-1:0] out_data,
    output logic      [W-1:0] direction,
    output logic      [W-1:0] pullup_enable,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_level
);
    import gp_pkg::*;

    logic [W-1:0] pin_meta;

    generate
        if (W < 1 || W > `GP_MAX_WIDTH) begin : g_bad
            $error("gp_port_bank: width out of range");
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            direction <= {W{`GP_DIR_RST}};
        end else if (!run) begin
            direction <= {W{`GP_DIR_RST}};
        end else if (wr_dir) begin
            direction <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pullup_enable <= {W{`GP_PULL_RST}};
        end else if (!run) begin
            pullup_enable <= {W{`GP_PULL_RST}};
        end else if (wr_pull) begin
            pullup_enable <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_data <= {W{`GP_DATA_RST}};
        end else if (!run) begin
            out_data <= {W{`GP_DATA_RST}};
        end else if (wr_data) begin
            out_data <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out <= {W{`GP_DATA_RST}};
        end else if (!run) begin
            pin_out <= {W{`GP_DATA_RST}};
        end else begin
            pin_out <= (func_sel & alt_out) | (~func_sel & out_data);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta  <= '0;
            pin_level <= '0;
        end else begin
            pin_meta  <= pin_in;
            pin_level <= pin_meta;
        end
    end

endmodule : gp_port_bank
`default_nettype wire

// *** gp_ports.sv ***
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module gp_ports #(
    parameter int P0_W        = `GP_P0_WIDTH,
    parameter int P2_W        = `GP_P2_WIDTH,
    parameter int P4_W        = `GP_P4_WIDTH,
    parameter int P5_W        = `GP_P5_WIDTH,
    parameter int STAB_CYCLES = `GP_STAB_CYCLES
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic            hready,
    input  wire logic [31:0]     hwdata,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic                 reset_done,
    input  wire logic [P0_W-1:0] p0_pin_in,
    output logic      [P0_W-1:0] p0_pin_out,
    output logic      [P0_W-1:0] p0_pin_oe,
    output logic      [P0_W-1:0] p0_pullup,
    input  wire logic [P2_W-1:0] p2_pin_in,
    output logic      [P2_W-1:0] p2_pin_out,
    output logic      [P2_W-1:0] p2_pin_oe,
    output logic      [P2_W-1:0] p2_pullup,
    input  wire logic [P2_W-1:0] p2_serial_out,
    output logic      [P2_W-1:0] p2_serial_in,
    input  wire logic [P4_W-1:0] p4_pin_in,
    output logic      [P4_W-1:0] p4_pin_out,
    output logic      [P4_W-1:0] p4_pin_oe,
    output logic      [P4_W-1:0] p4_pullup,
    input  wire logic [P5_W-1:0] p5_pin_in,
    output logic      [P5_W-1:0] p5_pin_out,
    output logic      [P5_W-1:0] p5_pin_oe,
    output logic      [P5_W-1:0] p5_pullup
);
    import gp_pkg::*;

    gp_bus_state_e            state;
    logic [`GP_ADDR_W-1:0]    addr_q;
    logic                     run;
    logic                     accept;
    logic                     wr_phase;
    logic [31:0]              read_word;
    logic [P2_W-1:0]          port2_pin_function_select;

    logic [P0_W-1:0]          port0_output_data;
    logic [P0_W-1:0]          port0_direction;
    logic [P0_W-1:0]          port0_pullup_enable;
    logic [P0_W-1:0]          port0_level;
    logic [P2_W-1:0]          port2_output_data;
    logic [P2_W-1:0]          port2_direction;
    logic [P2_W-1:0]          port2_pullup_enable;
    logic [P2_W-1:0]          port2_level;
    logic [P4_W-1:0]          port4_output_data;
    logic [P4_W-1:0]          port4_direction;
    logic [P4_W-1:0]          port4_pullup_enable;
    logic [P4_W-1:0]          port4_level;
    logic [P5_W-1:0]          port5_output_data;
    logic [P5_W-1:0]          port5_direction;
    logic [P5_W-1:0]          port5_pullup_enable;
    logic [P5_W-1:0]          port5_level;

    generate
        if (P0_W < 1 || P0_W > `GP_MAX_WIDTH || P2_W < 1 || P2_W > `GP_MAX_WIDTH ||
            P4_W < 1 || P4_W > `GP_MAX_WIDTH || P5_W < 1 || P5_W > `GP_MAX_WIDTH) begin : g_bad
            $error("gp_ports: port width out of range");
        end
    endgenerate

    gp_reset_ctl #(
        .STAB_CYCLES (STAB_CYCLES)
    ) u_reset_ctl (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (run)
    );

    assign reset_done = run;

    // Only the one slave; hready mirrors hreadyout, so a stalled phase is never taken
    assign accept   = hsel && htrans[`GP_HTRANS_ACT_BIT] && hready;
    assign wr_phase = (state == GP_BUS_WRITE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state  <= GP_BUS_IDLE;
            addr_q <= '0;
        end else if (!run) begin
            state  <= GP_BUS_IDLE;
        end else begin
            case (state)
                GP_BUS_IDLE, GP_BUS_WRITE: begin
                    if (accept) begin
                        addr_q <= haddr[`GP_ADDR_W-1:0];
                        state  <= hwrite ? GP_BUS_WRITE : GP_BUS_READ;
                    end else begin
                        state  <= GP_BUS_IDLE;
                    end
                end
                GP_BUS_READ: begin
                    state <= GP_BUS_IDLE;
                end
                default: begin
                    state <= GP_BUS_IDLE;
                end
            endcase
        end
    end

    // Reads take one wait state so a write just before is already stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= run && !(accept && !hwrite);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= `GP_HRESP_OKAY;
        end else begin
            hresp <= `GP_HRESP_OKAY;
        end
    end

    always_comb begin
        read_word = `GP_RDATA_RST;
        case (addr_q)
            `GP_OFS_P0_DATA: read_word = {{(32-P0_W){1'b0}}, port0_output_data};
            `GP_OFS_P0_DIR:  read_word = {{(32-P0_W){1'b0}}, port0_direction};
            `GP_OFS_P0_PULL: read_word = {{(32-P0_W){1'b0}}, port0_pullup_enable};
            `GP_OFS_P0_PIN:  read_word = {{(32-P0_W){1'b0}}, port0_level};
            `GP_OFS_P2_DATA: read_word = {{(32-P2_W){1'b0}}, port2_output_data};
            `GP_OFS_P2_DIR:  read_word = {{(32-P2_W){1'b0}}, port2_direction};
            `GP_OFS_P2_PULL: read_word = {{(32-P2_W){1'b0}}, port2_pullup_enable};
            `GP_OFS_P2_PIN:  read_word = {{(32-P2_W){1'b0}}, port2_level};
            `GP_OFS_P4_DATA: read_word = {{(32-P4_W){1'b0}}, port4_output_data};
            `GP_OFS_P4_DIR:  read_word = {{(32-P4_W){1'b0}}, port4_direction};
            `GP_OFS_P4_PULL: read_word = {{(32-P4_W){1'b0}}, port4_pullup_enable};
            `GP_OFS_P4_PIN:  read_word = {{(32-P4_W){1'b0}}, port4_level};
            `GP_OFS_P5_DATA: read_word = {{(32-P5_W){1'b0}}, port5_output_data};
            `GP_OFS_P5_DIR:  read_word = {{(32-P5_W){1'b0}}, port5_direction};
            `GP_OFS_P5_PULL: read_word = {{(32-P5_W){1'b0}}, port5_pullup_enable};
            `GP_OFS_P5_PIN:  read_word = {{(32-P5_W){1'b0}}, port5_level};
            `GP_OFS_P2_FUNC: read_word = {{(32-P2_W){1'b0}}, port2_pin_function_select};
            default:         read_word = `GP_RDATA_RST;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `GP_RDATA_RST;
        end else if (state == GP_BUS_READ) begin
            hrdata <= read_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port2_pin_function_select <= {P2_W{`GP_FUNC_RST}};
        end else if (!run) begin
            port2_pin_function_select <= {P2_W{`GP_FUNC_RST}};
        end else if (wr_phase && addr_q == `GP_OFS_P2_FUNC) begin
            port2_pin_function_select <= hwdata[P2_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p2_serial_in <= '0;
        end else begin
            p2_serial_in <= port2_level & port2_pin_function_select;
        end
    end

    assign p0_pin_oe = port0_direction;
    assign p2_pin_oe = port2_direction;
    assign p4_pin_oe = port4_direction;
    assign p5_pin_oe = port5_direction;
    assign p0_pullup = port0_pullup_enable;
    assign p2_pullup = port2_pullup_enable;
    assign p4_pullup = port4_pullup_enable;
    assign p5_pullup = port5_pullup_enable;

    gp_port_bank #(
        .W (P0_W)
    ) u_port0 (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .run           (run),
        .wr_data       (wr_phase && addr_q == `GP_OFS_P0_DATA),
        .wr_dir        (wr_phase && addr_q == `GP_OFS_P0_DIR),
        .wr_pull       (wr_phase && addr_q == `GP_OFS_P0_PULL),
        .wdata         (hwdata[P0_W-1:0]),
        .pin_in        (p0_pin_in),
        .func_sel      ({P0_W{`GP_FUNC_RST}}),
        .alt_out       ({P0_W{`GP_DATA_RST}}),
        .out_data      (port0_output_data),
        .direction     (port0_direction),
        .pullup_enable (port0_pullup_enable),
        .pin_out       (p0_pin_out),
        .pin_level     (port0_level)
    );

    gp_port_bank #(
        .W (P2_W)
    ) u_port2 (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .run           (run),
        .wr_data       (wr_phase && addr_q == `GP_OFS_P2_DATA),
        .wr_dir        (wr_phase && addr_q == `GP_OFS_P2_DIR),
        .wr_pull       (wr_phase && addr_q == `GP_OFS_P2_PULL),
        .wdata         (hwdata[P2_W-1:0]),
        .pin_in        (p2_pin_in),
        .func_sel      (port2_pin_function_select),
        .alt_out       (p2_serial_out),
        .out_data      (port2_output_data),
        .direction     (port2_direction),
        .pullup_enable (port2_pullup_enable),
        .pin_out       (p2_pin_out),
        .pin_level     (port2_level)
    );

    gp_port_bank #(
        .W (P4_W)
    ) u_port4 (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .run           (run),
        .wr_data       (wr_phase && addr_q == `GP_OFS_P4_DATA),
        .wr_dir        (wr_phase && addr_q == `GP_OFS_P4_DIR),
        .wr_pull       (wr_phase && addr_q == `GP_OFS_P4_PULL),
        .wdata         (hwdata[P4_W-1:0]),
        .pin_in        (p4_pin_in),
        .func_sel      ({P4_W{`GP_FUNC_RST}}),
        .alt_out       ({P4_W{`GP_DATA_RST}}),
        .out_data      (port4_output_data),
        .direction     (port4_direction),
        .pullup_enable (port4_pullup_enable),
        .pin_out       (p4_pin_out),
        .pin_level     (port4_level)
    );

    gp_port_bank #(
        .W (P5_W)
    ) u_port5 (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .run           (run),
        .wr_data       (wr_phase && addr_q == `GP_OFS_P5_DATA),
        .wr_dir        (wr_phase && addr_q == `GP_OFS_P5_DIR),
        .wr_pull       (wr_phase && addr_q == `GP_OFS_P5_PULL),
        .wdata         (hwdata[P5_W-1:0]),
        .pin_in        (p5_pin_in),
        .func_sel      ({P5_W{`GP_FUNC_RST}}),
        .alt_out       ({P5_W{`GP_DATA_RST}}),
        .out_data      (port5_output_data),
        .direction     (port5_direction),
        .pullup_enable (port5_pullup_enable),
        .pin_out       (p5_pin_out),
        .pin_level     (port5_level)
    );

endmodule : gp_ports
`default_nettype wire

// *** gp_ports_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gp_params.svh"
module gp_chk #(
    parameter int P0_W        = 4,
    parameter int P2_W        = 6,
    parameter int STAB_CYCLES = 8
) (
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hsel,
    input wire logic [31:0]     haddr,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic            hready,
    input wire logic [31:0]     hwdata,
    input wire logic            hreadyout,
    input wire logic            reset_done,
    input wire logic [P0_W-1:0] p0_pin_oe,
    input wire logic [P0_W-1:0] p0_pin_out,
    input wire logic [P2_W-1:0] p2_pullup,
    input wire logic [P2_W-1:0] p2_serial_in
);
    logic            tk;
    logic            wq;
    logic [7:0]      aq;
    logic [P2_W-1:0] fq;
    int              cnt;
    assign tk = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wq <= 1'b0;
            aq <= 8'h00;
        end else begin
            wq <= tk && hwrite;
            aq <= haddr[7:0];
        end
    end
    // Shadow of function select, follows data phase writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) fq <= '0;
        else if (wq && aq == `GP_OFS_P2_FUNC) fq <= hwdata[P2_W-1:0];
    end
    // Saturates so long runs cannot wrap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt <= 0;
        else if (cnt < STAB_CYCLES + 8) cnt <= cnt + 1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_held;
        !reset_done |-> p0_pin_oe == '0 && p0_pin_out == '0 && p2_pullup == '0;
    endproperty
    a_held: assert property (p_held)
        else $error("control outputs left reset value");
    property p_rdy;
        !reset_done |-> !hreadyout;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("bus ready before wait ended");
    property p_stab_e;
        $rose(reset_done) |-> cnt >= STAB_CYCLES && cnt <= STAB_CYCLES + 3;
    endproperty
    a_stab_e: assert property (p_stab_e)
        else $error("wait ended at wrong cycle");
    property p_stab_l;
        cnt > STAB_CYCLES + 3 |-> reset_done;
    endproperty
    a_stab_l: assert property (p_stab_l)
        else $error("wait never ended");
    property p_dir;
        wq && aq == `GP_OFS_P0_DIR |=> p0_pin_oe == P0_W'($past(hwdata));
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction write not applied");
    property p_pull;
        wq && aq == `GP_OFS_P2_PULL |=> p2_pullup == P2_W'($past(hwdata));
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up write not applied");
    property p_out;
        wq && aq == `GP_OFS_P0_DATA |=> ##1 p0_pin_out == P0_W'($past(hwdata, 2));
    endproperty
    a_out: assert property (p_out)
        else $error("pin output not following data");
    property p_rd;
        tk && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read timing wrong");
    property p_ser;
        (p2_serial_in & ~fq & ~$past(fq)) == '0;
    endproperty
    a_ser: assert property (p_ser)
        else $error("serial input passed while unselected");
endmodule : gp_chk
bind gp_ports gp_chk #(.P0_W(P0_W), .P2_W(P2_W), .STAB_CYCLES(STAB_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .reset_done(reset_done), .p0_pin_oe(p0_pin_oe), .p0_pin_out(p0_pin_out),
    .p2_pullup(p2_pullup), .p2_serial_in(p2_serial_in));
`default_nettype wire

// *** gp_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module gp_board #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] drv,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] lvl
);
    logic tgl = 1'b0;
    // Floating pin wanders so a stale value cannot pass
    always_ff @(posedge clk) tgl <= !tgl;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl[i] = oe[i] ? drv[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : tgl;
        end
    end
endmodule : gp_board
`default_nettype wire

// *** tb_general_purpose_io_ports.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_general_purpose_io_ports;
    localparam int STAB = 8;
    localparam logic [7:0] BASE [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
    localparam logic [5:0] MSK [4] = '{6'h0f, 6'h3f, 6'h03, 6'h03};
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, reset_done;
    logic [3:0]  p0_out, p0_oe, p0_pu, p0_in;
    logic [5:0]  p2_out, p2_oe, p2_pu, p2_in, ser_in, ser_out = 0;
    logic [1:0]  p4_out, p4_oe, p4_pu, p4_in, p5_out, p5_oe, p5_pu, p5_in;
    logic [5:0]  ext [4] = '{default: 0};
    logic [5:0]  een [4] = '{default: 0};
    logic [5:0]  oe_v [4], out_v [4], pu_v [4];
    int          failures = 0, checked = 0, cyc = 0;
    assign oe_v = '{{2'h0, p0_oe}, p2_oe, {4'h0, p4_oe}, {4'h0, p5_oe}};
    assign out_v = '{{2'h0, p0_out}, p2_out, {4'h0, p4_out}, {4'h0, p5_out}};
    assign pu_v = '{{2'h0, p0_pu}, p2_pu, {4'h0, p4_pu}, {4'h0, p5_pu}};
    gp_ports #(.STAB_CYCLES(STAB)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_done(reset_done),
        .p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p0_pullup(p0_pu),
        .p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe(p2_oe), .p2_pullup(p2_pu),
        .p2_serial_out(ser_out), .p2_serial_in(ser_in),
        .p4_pin_in(p4_in), .p4_pin_out(p4_out), .p4_pin_oe(p4_oe), .p4_pullup(p4_pu),
        .p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p5_pullup(p5_pu));
    gp_board #(.W(4)) u_b0 (.clk(hclk), .drv(p0_out), .oe(p0_oe), .pu(p0_pu),
        .ext(ext[0][3:0]), .ext_en(een[0][3:0]), .lvl(p0_in));
    gp_board #(.W(6)) u_b2 (.clk(hclk), .drv(p2_out), .oe(p2_oe), .pu(p2_pu),
        .ext(ext[1]), .ext_en(een[1]), .lvl(p2_in));
    gp_board #(.W(2)) u_b4 (.clk(hclk), .drv(p4_out), .oe(p4_oe), .pu(p4_pu),
        .ext(ext[2][1:0]), .ext_en(een[2][1:0]), .lvl(p4_in));
    gp_board #(.W(2)) u_b5 (.clk(hclk), .drv(p5_out), .oe(p5_oe), .pu(p5_pu),
        .ext(ext[3][1:0]), .ext_en(een[3][1:0]), .lvl(p5_in));
    initial begin
        forever #5 hclk = ~hclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    // Address phase held until ready, then data phase held until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic rchk(input logic [7:0] a, input logic [5:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK("hrdata", {26'h0, e}, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask : rchk
    task automatic wait_done;
        int n;
        n = 0;
        while (reset_done !== 1'b1) begin
            @(posedge hclk);
            n++;
        end
        `CHK("wait", 1'b1, n >= STAB && n <= STAB + 3)
    endtask : wait_done
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        `CHK("oe in reset", 6'h00, oe_v[1])
        hresetn <= 1'b1;
        wait_done();
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            rchk(BASE[p] + 8'h04, 6'h00);
            rchk(BASE[p] + 8'h08, 6'h00);
            xfer(1'b1, BASE[p] + 8'h04, 32'hffff_ffff);
            rchk(BASE[p] + 8'h04, MSK[p]);
            `CHK("oe", MSK[p], oe_v[p])
            xfer(1'b1, BASE[p], 32'h0000_0035);
            rchk(BASE[p], 6'h35 & MSK[p]);
            repeat (4) @(posedge hclk);
            #1 `CHK("pin out", 6'h35 & MSK[p], out_v[p])
            rchk(BASE[p] + 8'h0c, 6'h35 & MSK[p]);
            xfer(1'b1, BASE[p] + 8'h04, 32'h0);
            ext[p] <= 6'h0a;
            een[p] <= 6'h3f;
            repeat (4) @(posedge hclk);
            rchk(BASE[p] + 8'h0c, 6'h0a & MSK[p]);
            een[p] <= 6'h00;
            xfer(1'b1, BASE[p] + 8'h08, 32'hffff_ffff);
            rchk(BASE[p] + 8'h08, MSK[p]);
            `CHK("pullup", MSK[p], pu_v[p])
            repeat (4) @(posedge hclk);
            rchk(BASE[p] + 8'h0c, MSK[p]);
            xfer(1'b1, BASE[p] + 8'h08, 32'h0);
        end
        $display("test ports done");
        xfer(1'b1, 8'h14, 32'h0000_003f);
        xfer(1'b1, 8'h10, 32'h0);
        ser_out <= 6'h2d;
        xfer(1'b1, 8'h40, 32'h0000_000f);
        repeat (4) @(posedge hclk);
        #1 `CHK("serial pin out", 6'h0d, out_v[1])
        `CHK("serial dir", 6'h3f, oe_v[1])
        `CHK("serial in", 6'h0d, ser_in)
        rchk(8'h40, 6'h0f);
        xfer(1'b1, 8'h44, 32'hffff_ffff);
        rchk(8'h44, 6'h00);
        $display("test serial done");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1 `CHK("oe mid reset", 6'h00, oe_v[1])
        `CHK("done mid reset", 1'b0, reset_done)
        @(posedge hclk);
        hresetn <= 1'b1;
        wait_done();
        rchk(8'h14, 6'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule : tb_general_purpose_io_ports
`default_nettype wire
